// >>> design/cbs_host.sv
`timescale 1ns/1ps
`include "cbs_cfg.svh"
// Notes on behaviour
// - Card audio forwarded to speaker output
// - Lock gives initiator exclusive target access
// - Detect plus sense pins give presence, voltage
// - Bridge claims addressed cycles with device select
// - No device select before timeout: initiator abort
// - Initiator drives frame from transaction start
// - Frame released marks the final data phase
// - Grant only after current transaction completes
// - Card pulls interrupt low for service
// - Phase completes when both readies sampled low
// - Each side signals readiness with own ready
// - Target flags parity error two clocks later
// - No parity error reporting in special cycles
// - Card requests bus through request line
// - Card system error may release slowly
// - Card system error forwarded to host
// - Target stop makes initiator end transfer
// - Stop used to disconnect after one transfer
// - Status change is alert and wake event
// - Even parity, driven one clock late, checked
// - Command in address, byte enables in data
module cbs_host #(
  parameter logic [31:0] TGT_BASE = 32'h0000_1000,
  parameter logic [31:0] TGT_MASK = 32'hffff_ff00
) (
  input  wire logic              core_clk_i,      // Socket clock
  input  wire logic              rst_n_i,         // Async reset, active low
  cbs_if.host_mp                 bus,             // Socket pins
  input  wire logic              req_i,           // Start one transaction
  input  wire logic [3:0]        req_cmd_i,       // Bus command
  input  wire logic [31:0]       req_addr_i,      // Address
  input  wire logic [31:0]       req_wdata_i,     // Write data
  input  wire logic [3:0]        req_be_i,        // Byte enables, active high
  output logic                   req_ready_o,     // Request may be taken
  output logic                   done_o,          // Transfer completed
  output logic                   abort_o,         // Initiator abort
  output logic                   stopped_o,       // Ended by target stop
  output logic [31:0]            rdata_o,         // Read data
  output logic [31:0]            tgt_word_o,      // Word served to the card
  output logic                   perr_evt_o,      // Parity error flagged
  output logic                   speaker_out_o,   // Speaker drive
  output logic                   card_present_o,  // Card inserted
  output cbs_pkg::cbs_volt_t     card_volt_o,     // Card voltage class
  output logic                   card_irq_o,      // Card wants service
  input  wire logic              serr_fwd_en_i,   // Forward card system error
  output logic                   host_serr_n_o,   // Host system error
  output logic                   status_alert_o,  // Status change pulse
  output logic                   wake_o,          // Sticky wake event
  input  wire logic              wake_clr_i       // Clear wake event
);
  import cbs_pkg::*;

  cbs_host_s_t q, n;
  logic        bus_idle;
  logic        start;
  logic        claim;
  logic [1:0]  vs;

  // ****************************************
  // Start and claim decisions
  // ****************************************
  assign bus_idle    = bus.ctl.frame_n & bus.ctl.irdy_n;
  // Another initiator holding lock keeps us off the bus
  assign req_ready_o = (q.e.st == CBS_ST_IDLE) & q.gnt_n & bus_idle & bus.ctl.lock_n;
  assign start       = req_i & req_ready_o;
  assign claim       = (q.e.st == CBS_ST_IDLE) & ~bus.ctl.frame_n & q.e.frame_prev
                     & ((bus.ad & TGT_MASK) == TGT_BASE)
                     & ((bus.cbe == `CBS_CMD_MEM_RD) | (bus.cbe == `CBS_CMD_MEM_WR));
  assign vs          = {bus.volt_sense_b, bus.volt_sense_a};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = q;
    n.e.done       = 1'b0;
    n.e.abort      = 1'b0;
    n.e.stopped    = 1'b0;
    n.e.perr_evt   = 1'b0;
    n.e.pend       = 1'b0;
    n.e.frame_prev = bus.ctl.frame_n;
    // Parity of the lines as seen, so a target read covers the initiator's byte enables
    n.e.ctl_o.par  = ^{bus.ad, bus.cbe};
    n.e.ctl_oe.par = q.e.ad_oe;
    n.e.ctl_o.perr_n  = 1'b1;
    n.e.ctl_oe.perr_n = 1'b0;
    if (q.e.pend && (bus.ctl.par != q.e.dp)) begin
      n.e.ctl_o.perr_n  = 1'b0;
      n.e.ctl_oe.perr_n = 1'b1;
      n.e.perr_evt      = 1'b1;
    end
    unique case (q.e.st)
      CBS_ST_IDLE: begin
        if (start) begin
          n.e.st            = CBS_ST_ADDR;
          n.e.ctl_o.frame_n = 1'b0;
          n.e.ctl_oe.frame_n = 1'b1;
          n.e.ctl_o.irdy_n  = 1'b1;
          n.e.ctl_oe.irdy_n = 1'b1;
          n.e.ad_o          = req_addr_i;
          n.e.ad_oe         = 1'b1;
          n.e.cbe_o         = req_cmd_i;
          n.e.cbe_oe        = 1'b1;
          n.e.wr            = req_cmd_i[0];
          n.e.wdata         = req_wdata_i;
          n.e.be            = req_be_i;
          n.e.cnt           = 3'h0;
        end else if (claim) begin
          n.e.st = CBS_ST_TDATA;
          n.e.wr = bus.cbe[0];
          n.e.ctl_o.devsel_n  = 1'b0;
          n.e.ctl_o.trdy_n    = 1'b0;
          n.e.ctl_o.stop_n    = 1'b0;
          n.e.ctl_oe.devsel_n = 1'b1;
          n.e.ctl_oe.trdy_n   = 1'b1;
          n.e.ctl_oe.stop_n   = 1'b1;
          n.e.ad_o  = q.e.store;
          n.e.ad_oe = ~bus.cbe[0];
        end
      end
      CBS_ST_ADDR: begin
        // Single data phase, so frame rises with the first one
        n.e.st            = CBS_ST_DATA;
        n.e.ctl_o.frame_n = 1'b1;
        n.e.ctl_o.irdy_n  = 1'b0;
        n.e.cbe_o         = ~q.e.be;
        n.e.ad_o          = q.e.wdata;
        n.e.ad_oe         = q.e.wr;
        n.e.cnt           = 3'h1;
      end
      CBS_ST_DATA: begin
        if (q.e.cnt != `CBS_DEVSEL_TMO) begin
          n.e.cnt = q.e.cnt + 3'h1;
        end
        if (~bus.ctl.trdy_n && ~bus.ctl.devsel_n) begin
          n.e.done  = 1'b1;
          n.e.rdata = q.e.wr ? q.e.rdata : bus.ad;
          n.e.st    = CBS_ST_TURN;
        end else if (~bus.ctl.stop_n) begin
          n.e.stopped = 1'b1;
          n.e.st      = CBS_ST_TURN;
        end else if (bus.ctl.devsel_n && q.e.cnt == `CBS_DEVSEL_TMO) begin
          n.e.abort = 1'b1;
          n.e.st    = CBS_ST_TURN;
        end
        if (n.e.st == CBS_ST_TURN) begin
          n.e.ctl_o.irdy_n   = 1'b1;
          n.e.ctl_oe.frame_n = 1'b0;
          n.e.ad_oe          = 1'b0;
          n.e.cbe_oe         = 1'b0;
        end
      end
      CBS_ST_TURN: begin
        n.e.ctl_oe.irdy_n = 1'b0;
        n.e.st            = CBS_ST_IDLE;
      end
      CBS_ST_TDATA: begin
        if (~bus.ctl.irdy_n) begin
          if (q.e.wr) begin
            for (int i = 0; i < 4; i++) begin
              if (~bus.cbe[i]) begin
                n.e.store[8*i +: 8] = bus.ad[8*i +: 8];
              end
            end
          end
          // Writes only; special cycles are never claimed
          n.e.pend = q.e.wr;
          n.e.dp   = ^{bus.ad, bus.cbe};
          n.e.ctl_o.devsel_n = 1'b1;
          n.e.ctl_o.trdy_n   = 1'b1;
          n.e.ctl_o.stop_n   = 1'b1;
          n.e.ad_oe          = 1'b0;
          n.e.st             = CBS_ST_TTURN;
        end
      end
      CBS_ST_TTURN: begin
        n.e.ctl_oe.devsel_n = 1'b0;
        n.e.ctl_oe.trdy_n   = 1'b0;
        n.e.ctl_oe.stop_n   = 1'b0;
        n.e.st              = CBS_ST_IDLE;
      end
    endcase

    // ****************************************
    // Arbiter and socket status
    // ****************************************
    if (bus.card_request_n) begin
      n.gnt_n = 1'b1;
    end else if (q.gnt_n) begin
      n.gnt_n = ~((q.e.st == CBS_ST_IDLE) & ~start & bus_idle);
    end
    n.audio   = bus.card_audio_in;
    n.present = ~bus.card_detect_a & ~bus.card_detect_b;
    if (!n.present) begin
      n.volt = CBS_V_NONE;
    end else if (vs == `CBS_VS_5V) begin
      n.volt = CBS_V_5;
    end else if (vs == `CBS_VS_3V) begin
      n.volt = CBS_V_3;
    end else begin
      n.volt = CBS_V_LOW;
    end
    n.irq      = ~bus.card_irq_n;
    // Level follow-through tolerates a slow pull-up release
    n.serr_n   = ~(serr_fwd_en_i & ~bus.card_system_error_n);
    n.sts_prev = bus.card_status_change;
    n.sts_evt  = bus.card_status_change & ~q.sts_prev;
    n.wake     = n.sts_evt | (q.wake & ~wake_clr_i);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q              <= '0;
      q.e.st         <= CBS_ST_IDLE;
      q.e.ctl_o      <= `CBS_CTL_REL;
      q.e.frame_prev <= 1'b1;
      q.gnt_n        <= 1'b1;
      q.volt         <= CBS_V_NONE;
      q.serr_n       <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus.h_ctl_o      = q.e.ctl_o;
  assign bus.h_ctl_oe     = q.e.ctl_oe;
  assign bus.h_ad_o       = q.e.ad_o;
  assign bus.h_ad_oe      = q.e.ad_oe;
  assign bus.h_cbe_o      = q.e.cbe_o;
  assign bus.h_cbe_oe     = q.e.cbe_oe;
  assign bus.card_grant_n = q.gnt_n;
  assign done_o           = q.e.done;
  assign abort_o          = q.e.abort;
  assign stopped_o        = q.e.stopped;
  assign rdata_o          = q.e.rdata;
  assign tgt_word_o       = q.e.store;
  assign perr_evt_o       = q.e.perr_evt;
  assign speaker_out_o    = q.audio;
  assign card_present_o   = q.present;
  assign card_volt_o      = q.volt;
  assign card_irq_o       = q.irq;
  assign host_serr_n_o    = q.serr_n;
  assign status_alert_o   = q.sts_evt;
  assign wake_o           = q.wake;
endmodule : cbs_host

// >>> design/cbs_cfg.svh
`ifndef CBS_CFG_SVH
`define CBS_CFG_SVH

// ****************************************
// Bus commands on the command/byte-enable lines
// ****************************************
`define CBS_CMD_SPECIAL 4'h1
`define CBS_CMD_MEM_RD  4'h6
`define CBS_CMD_MEM_WR  4'h7

// ****************************************
// Timing and sense codes
// ****************************************
`define CBS_DEVSEL_TMO  3'h5
`define CBS_VS_5V       2'h3
`define CBS_VS_3V       2'h2
`define CBS_CTL_REL     8'hff

`endif

// >>> design/cbs_pkg.sv
package cbs_pkg;

  // Shared control lines, all active low except parity
  typedef struct packed {
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic devsel_n;
    logic stop_n;
    logic perr_n;
    logic lock_n;
    logic par;
  } cbs_ctl_t;

  typedef enum logic [1:0] {CBS_V_NONE, CBS_V_5, CBS_V_3, CBS_V_LOW} cbs_volt_t;

  typedef enum logic [2:0] {
    CBS_ST_IDLE, CBS_ST_ADDR, CBS_ST_DATA, CBS_ST_TURN, CBS_ST_TDATA, CBS_ST_TTURN
  } cbs_st_t;

  // Bus engine state common to both ends
  typedef struct packed {
    cbs_st_t    st;
    logic [2:0] cnt;
    cbs_ctl_t   ctl_o;
    cbs_ctl_t   ctl_oe;
    logic [31:0] ad_o;
    logic       ad_oe;
    logic [3:0] cbe_o;
    logic       cbe_oe;
    logic       wr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] rdata;
    logic [31:0] store;
    logic       done;
    logic       abort;
    logic       stopped;
    logic       frame_prev;
    logic       pend;
    logic       dp;
    logic       perr_evt;
  } cbs_eng_t;

  typedef struct packed {
    cbs_eng_t  e;
    logic      gnt_n;
    logic      audio;
    logic      present;
    cbs_volt_t volt;
    logic      irq;
    logic      serr_n;
    logic      sts_prev;
    logic      sts_evt;
    logic      wake;
  } cbs_host_s_t;

  typedef struct packed {
    cbs_eng_t  e;
    logic      req_n;
    logic      irq_n;
    logic      serr_n;
    logic      sts;
    logic      audio;
    logic      cd_a;
    logic      cd_b;
    logic      vs_a;
    logic      vs_b;
  } cbs_card_s_t;

endpackage : cbs_pkg

// >>> design/cbs_if.sv
`timescale 1ns/1ps
interface cbs_if;
  import cbs_pkg::*;

  cbs_ctl_t    h_ctl_o, h_ctl_oe, c_ctl_o, c_ctl_oe, ctl;
  logic [31:0] h_ad_o, c_ad_o, ad;
  logic        h_ad_oe, c_ad_oe;
  logic [3:0]  h_cbe_o, c_cbe_o, cbe;
  logic        h_cbe_oe, c_cbe_oe;
  logic        card_grant_n;
  logic        card_request_n;
  logic        card_irq_n;
  logic        card_system_error_n;
  logic        card_status_change;
  logic        card_audio_in;
  logic        card_detect_a;
  logic        card_detect_b;
  logic        volt_sense_a;
  logic        volt_sense_b;

  // ****************************************
  // Wire levels with pull-ups on released lines
  // ****************************************
  assign ctl = (h_ctl_oe & h_ctl_o) | (~h_ctl_oe & c_ctl_oe & c_ctl_o) | (~h_ctl_oe & ~c_ctl_oe);
  assign ad  = h_ad_oe ? h_ad_o : (c_ad_oe ? c_ad_o : 32'hffff_ffff);
  assign cbe = h_cbe_oe ? h_cbe_o : (c_cbe_oe ? c_cbe_o : 4'hf);

  modport host_mp (
    output h_ctl_o, h_ctl_oe, h_ad_o, h_ad_oe, h_cbe_o, h_cbe_oe, card_grant_n,
    input  ctl, ad, cbe, card_request_n, card_irq_n, card_system_error_n,
    input  card_status_change, card_audio_in, card_detect_a, card_detect_b,
    input  volt_sense_a, volt_sense_b
  );

  modport card_mp (
    output c_ctl_o, c_ctl_oe, c_ad_o, c_ad_oe, c_cbe_o, c_cbe_oe, card_request_n,
    output card_irq_n, card_system_error_n, card_status_change, card_audio_in,
    output card_detect_a, card_detect_b, volt_sense_a, volt_sense_b,
    input  ctl, ad, cbe, card_grant_n
  );
endinterface : cbs_if

// >>> design/cbs_card.sv
`timescale 1ns/1ps
`include "cbs_cfg.svh"
module cbs_card #(
  parameter logic [31:0] TGT_BASE = 32'h0000_2000,
  parameter logic [31:0] TGT_MASK = 32'hffff_ff00
) (
  input  wire logic        core_clk_i,   // Socket clock
  input  wire logic        rst_n_i,      // Async reset, active low
  cbs_if.card_mp           bus,          // Socket pins
  input  wire logic        req_i,        // Want one transaction
  input  wire logic [3:0]  req_cmd_i,    // Bus command
  input  wire logic [31:0] req_addr_i,   // Address
  input  wire logic [31:0] req_wdata_i,  // Write data
  input  wire logic [3:0]  req_be_i,     // Byte enables, active high
  input  wire logic        lock_i,       // Hold lock over own transactions
  output logic             req_ready_o,  // Request may be taken
  output logic             done_o,       // Transfer completed
  output logic             abort_o,      // Initiator abort
  output logic             stopped_o,    // Ended by target stop
  output logic [31:0]      rdata_o,      // Read data
  output logic [31:0]      tgt_word_o,   // Word served to the bridge
  output logic             perr_evt_o,   // Parity error flagged
  input  wire logic        irq_i,        // Interrupt request
  input  wire logic        serr_i,       // System error
  input  wire logic        sts_chg_i,    // Status change
  input  wire logic        audio_i,      // Binary audio
  input  wire logic [1:0]  detect_n_i,   // Detect straps, b then a
  input  wire logic [1:0]  vsense_i      // Sense straps, b then a
);
  import cbs_pkg::*;

  cbs_card_s_t q, n;
  logic        start;
  logic        claim;

  assign req_ready_o = (q.e.st == CBS_ST_IDLE) & ~bus.card_grant_n
                     & bus.ctl.frame_n & bus.ctl.irdy_n;
  assign start       = req_i & req_ready_o;
  assign claim       = (q.e.st == CBS_ST_IDLE) & ~bus.ctl.frame_n & q.e.frame_prev
                     & ((bus.ad & TGT_MASK) == TGT_BASE)
                     & ((bus.cbe == `CBS_CMD_MEM_RD) | (bus.cbe == `CBS_CMD_MEM_WR));

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = q;
    n.e.done       = 1'b0;
    n.e.abort      = 1'b0;
    n.e.stopped    = 1'b0;
    n.e.perr_evt   = 1'b0;
    n.e.pend       = 1'b0;
    n.e.frame_prev = bus.ctl.frame_n;
    n.e.ctl_o.par  = ^{bus.ad, bus.cbe};
    n.e.ctl_oe.par = q.e.ad_oe;
    n.e.ctl_o.perr_n  = 1'b1;
    n.e.ctl_oe.perr_n = 1'b0;
    if (q.e.pend && (bus.ctl.par != q.e.dp)) begin
      n.e.ctl_o.perr_n  = 1'b0;
      n.e.ctl_oe.perr_n = 1'b1;
      n.e.perr_evt      = 1'b1;
    end
    unique case (q.e.st)
      CBS_ST_IDLE: begin
        if (start) begin
          n.e.st             = CBS_ST_ADDR;
          n.e.ctl_o.frame_n  = 1'b0;
          n.e.ctl_oe.frame_n = 1'b1;
          n.e.ctl_o.irdy_n   = 1'b1;
          n.e.ctl_oe.irdy_n  = 1'b1;
          n.e.ctl_o.lock_n   = ~lock_i;
          n.e.ctl_oe.lock_n  = lock_i | q.e.ctl_oe.lock_n;
          n.e.ad_o   = req_addr_i;
          n.e.ad_oe  = 1'b1;
          n.e.cbe_o  = req_cmd_i;
          n.e.cbe_oe = 1'b1;
          n.e.wr     = req_cmd_i[0];
          n.e.wdata  = req_wdata_i;
          n.e.be     = req_be_i;
          n.e.cnt    = 3'h0;
        end else if (claim) begin
          n.e.st = CBS_ST_TDATA;
          n.e.wr = bus.cbe[0];
          n.e.ctl_o.devsel_n  = 1'b0;
          n.e.ctl_o.trdy_n    = 1'b0;
          n.e.ctl_o.stop_n    = 1'b0;
          n.e.ctl_oe.devsel_n = 1'b1;
          n.e.ctl_oe.trdy_n   = 1'b1;
          n.e.ctl_oe.stop_n   = 1'b1;
          n.e.ad_o  = q.e.store;
          n.e.ad_oe = ~bus.cbe[0];
        end else if (!lock_i) begin
          // Lock is dropped only between transactions
          n.e.ctl_o.lock_n  = 1'b1;
          n.e.ctl_oe.lock_n = 1'b0;
        end
      end
      CBS_ST_ADDR: begin
        n.e.st            = CBS_ST_DATA;
        n.e.ctl_o.frame_n = 1'b1;
        n.e.ctl_o.irdy_n  = 1'b0;
        n.e.cbe_o         = ~q.e.be;
        n.e.ad_o          = q.e.wdata;
        n.e.ad_oe         = q.e.wr;
        n.e.cnt           = 3'h1;
      end
      CBS_ST_DATA: begin
        if (q.e.cnt != `CBS_DEVSEL_TMO) begin
          n.e.cnt = q.e.cnt + 3'h1;
        end
        if (~bus.ctl.trdy_n && ~bus.ctl.devsel_n) begin
          n.e.done  = 1'b1;
          n.e.rdata = q.e.wr ? q.e.rdata : bus.ad;
          n.e.st    = CBS_ST_TURN;
        end else if (~bus.ctl.stop_n) begin
          n.e.stopped = 1'b1;
          n.e.st      = CBS_ST_TURN;
        end else if (bus.ctl.devsel_n && q.e.cnt == `CBS_DEVSEL_TMO) begin
          n.e.abort = 1'b1;
          n.e.st    = CBS_ST_TURN;
        end
        if (n.e.st == CBS_ST_TURN) begin
          n.e.ctl_o.irdy_n   = 1'b1;
          n.e.ctl_oe.frame_n = 1'b0;
          n.e.ad_oe          = 1'b0;
          n.e.cbe_oe         = 1'b0;
        end
      end
      CBS_ST_TURN: begin
        n.e.ctl_oe.irdy_n = 1'b0;
        n.e.st            = CBS_ST_IDLE;
      end
      CBS_ST_TDATA: begin
        if (~bus.ctl.irdy_n) begin
          if (q.e.wr) begin
            for (int i = 0; i < 4; i++) begin
              if (~bus.cbe[i]) begin
                n.e.store[8*i +: 8] = bus.ad[8*i +: 8];
              end
            end
          end
          n.e.pend = q.e.wr;
          n.e.dp   = ^{bus.ad, bus.cbe};
          n.e.ctl_o.devsel_n = 1'b1;
          n.e.ctl_o.trdy_n   = 1'b1;
          n.e.ctl_o.stop_n   = 1'b1;
          n.e.ad_oe          = 1'b0;
          n.e.st             = CBS_ST_TTURN;
        end
      end
      CBS_ST_TTURN: begin
        n.e.ctl_oe.devsel_n = 1'b0;
        n.e.ctl_oe.trdy_n   = 1'b0;
        n.e.ctl_oe.stop_n   = 1'b0;
        n.e.st              = CBS_ST_IDLE;
      end
    endcase
    n.req_n  = ~(req_i & (q.e.st == CBS_ST_IDLE));
    n.irq_n  = ~irq_i;
    n.serr_n = ~serr_i;
    n.sts    = sts_chg_i;
    n.audio  = audio_i;
    n.cd_a   = detect_n_i[0];
    n.cd_b   = detect_n_i[1];
    n.vs_a   = vsense_i[0];
    n.vs_b   = vsense_i[1];
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q              <= '0;
      q.e.st         <= CBS_ST_IDLE;
      q.e.ctl_o      <= `CBS_CTL_REL;
      q.e.frame_prev <= 1'b1;
      q.req_n        <= 1'b1;
      q.irq_n        <= 1'b1;
      q.serr_n       <= 1'b1;
      q.cd_a         <= 1'b1;
      q.cd_b         <= 1'b1;
      q.vs_a         <= 1'b1;
      q.vs_b         <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign bus.c_ctl_o             = q.e.ctl_o;
  assign bus.c_ctl_oe            = q.e.ctl_oe;
  assign bus.c_ad_o              = q.e.ad_o;
  assign bus.c_ad_oe             = q.e.ad_oe;
  assign bus.c_cbe_o             = q.e.cbe_o;
  assign bus.c_cbe_oe            = q.e.cbe_oe;
  assign bus.card_request_n      = q.req_n;
  assign bus.card_irq_n          = q.irq_n;
  assign bus.card_system_error_n = q.serr_n;
  assign bus.card_status_change  = q.sts;
  assign bus.card_audio_in       = q.audio;
  assign bus.card_detect_a       = q.cd_a;
  assign bus.card_detect_b       = q.cd_b;
  assign bus.volt_sense_a        = q.vs_a;
  assign bus.volt_sense_b        = q.vs_b;
  assign done_o                  = q.e.done;
  assign abort_o                 = q.e.abort;
  assign stopped_o               = q.e.stopped;
  assign rdata_o                 = q.e.rdata;
  assign tgt_word_o              = q.e.store;
  assign perr_evt_o              = q.e.perr_evt;
endmodule : cbs_card

// >>> tb/cbs_props.sv
`timescale 1ns/1ps
module cbs_props (
  input wire logic         core_clk_i,     // Socket clock
  input wire logic         rst_n_i,        // Reset, active low
  input cbs_pkg::cbs_ctl_t ctl,            // Resolved control lines
  input cbs_pkg::cbs_ctl_t h_ctl_oe,       // Host line enables
  input wire logic [31:0]  ad,             // Address/data
  input wire logic [3:0]   cbe,            // Command/byte enables
  input wire logic         card_grant_n,   // Grant
  input wire logic         card_request_n  // Request
);
  import cbs_pkg::*;
  // ****************************************
  // Socket protocol checks
  // ****************************************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic mine = (ad[31:8] == 24'h10 || ad[31:8] == 24'h20) && cbe[3:1] == 3'h3;
  sequence s_start; $fell(ctl.frame_n); endsequence
  sequence s_phase; !ctl.irdy_n && (!ctl.trdy_n || !ctl.stop_n); endsequence
  chk_target_claim: assert property (s_start and mine |=> !ctl.devsel_n)
    else $error("target claim missing");
  chk_frame_last: assert property (s_start |=> ctl.frame_n && !ctl.irdy_n)
    else $error("frame not ended");
  chk_abort_end: assert property (s_start |-> ##[2:8] ctl.irdy_n)
    else $error("transfer never ended");
  chk_phase_end: assert property (s_phase |=> ctl.irdy_n)
    else $error("phase not ended");
  chk_par_even: assert property (!ctl.frame_n || !ctl.devsel_n |=>
    ctl.par == ^{$past(ad), $past(cbe)})
    else $error("bad parity");
  chk_perr_slot: assert property ($fell(ctl.perr_n) |-> $past(ctl.devsel_n, 2) == 1'b0)
    else $error("parity error misplaced");
  chk_grant_idle: assert property ($fell(card_grant_n) |-> $past(ctl.frame_n) && $past(ctl.irdy_n))
    else $error("grant while busy");
  chk_grant_req: assert property (!card_grant_n |-> $past(card_request_n) == 1'b0)
    else $error("grant without request");
  chk_lock_excl: assert property ($rose(h_ctl_oe.frame_n) |-> $past(ctl.lock_n))
    else $error("host start under lock");
endmodule : cbs_props

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "cbs_cfg.svh"
module testbench;
  import cbs_pkg::*;
  logic        clk, rst_n, fen, wclr, lk, irq, serr, sts, aud, spk, pres, cirq, hserr, alert, wake;
  logic [1:0]  det, vs;
  logic        rq [2], rdy [2], dn [2], ab [2], st [2], pe [2];
  logic [3:0]  cm [2], be [2], b;
  logic [31:0] ad [2], wd [2], rd [2], tw [2], ex [2];
  logic [2:0]  r;
  cbs_volt_t   volt;
  int          n_mismatch, compares, seed, n_perr;
  cbs_if bus_if ();
  cbs_host cbs_host_i (.core_clk_i(clk), .rst_n_i(rst_n), .bus(bus_if.host_mp), .req_i(rq[0]),
    .req_cmd_i(cm[0]), .req_addr_i(ad[0]), .req_wdata_i(wd[0]), .req_be_i(be[0]),
    .req_ready_o(rdy[0]), .done_o(dn[0]), .abort_o(ab[0]), .stopped_o(st[0]), .rdata_o(rd[0]),
    .tgt_word_o(tw[0]), .perr_evt_o(pe[0]), .speaker_out_o(spk), .card_present_o(pres),
    .card_volt_o(volt), .card_irq_o(cirq), .serr_fwd_en_i(fen), .host_serr_n_o(hserr),
    .status_alert_o(alert), .wake_o(wake), .wake_clr_i(wclr));
  cbs_card cbs_card_i (.core_clk_i(clk), .rst_n_i(rst_n), .bus(bus_if.card_mp), .req_i(rq[1]),
    .req_cmd_i(cm[1]), .req_addr_i(ad[1]), .req_wdata_i(wd[1]), .req_be_i(be[1]), .lock_i(lk),
    .req_ready_o(rdy[1]), .done_o(dn[1]), .abort_o(ab[1]), .stopped_o(st[1]), .rdata_o(rd[1]),
    .tgt_word_o(tw[1]), .perr_evt_o(pe[1]), .irq_i(irq), .serr_i(serr), .sts_chg_i(sts),
    .audio_i(aud), .detect_n_i(det), .vsense_i(vs));
  cbs_props cbs_props_i (.core_clk_i(clk), .rst_n_i(rst_n), .ctl(bus_if.ctl),
    .h_ctl_oe(bus_if.h_ctl_oe), .ad(bus_if.ad), .cbe(bus_if.cbe),
    .card_grant_n(bus_if.card_grant_n), .card_request_n(bus_if.card_request_n));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic final_report();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] m);
    for (int i = 0; i < 4; i++) if (m[i]) o[8*i +: 8] = n[8*i +: 8];
    return o;
  endfunction : merge
  function automatic cbs_volt_t vexp(logic [1:0] v, logic [1:0] d);
    if (d != 2'h0) return CBS_V_NONE;
    return v == 2'h3 ? CBS_V_5 : (v == 2'h2 ? CBS_V_3 : CBS_V_LOW);
  endfunction : vexp
  // One transaction from side s, answer as {done, stopped, abort}
  task automatic xfer(input int s, input logic [3:0] c, input logic [31:0] a,
                      input logic [3:0] m, output logic [2:0] res);
    int n;
    n = 0;
    cm[s] = c;
    ad[s] = a;
    wd[s] = $random(seed);
    be[s] = m;
    rq[s] = 1'b1;
    while (rdy[s] !== 1'b1 && n < 60) begin @(negedge clk); n++; end
    @(negedge clk);
    rq[s] = 1'b0;
    res = 3'h0;
    while (res === 3'h0 && n < 90) begin @(negedge clk); n++; res = {dn[s], st[s], ab[s]}; end
    repeat (3) @(negedge clk);
  endtask : xfer
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (pe[0] === 1'b1 || pe[1] === 1'b1) n_perr++;
  end
  initial begin
    #50000;
    n_mismatch++;
    final_report();
  end
  initial begin
    seed = 32'h2a39;
    {rst_n, fen, wclr, lk, irq, serr, sts, aud, vs, det} = 12'h003;
    foreach (cm[i]) begin rq[i] = 0; cm[i] = 0; ad[i] = 0; wd[i] = 0; be[i] = 0; end
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    for (int s = 0; s < 2; s++) begin
      lk = s[0];
      for (int k = 0; k < 5; k++) begin
        b = k ? 4'($random(seed)) : 4'hf;
        xfer(s, `CBS_CMD_MEM_WR, (32'h2000 >> s) | (32'($random(seed)) & 32'hfc), b, r);
        ex[1-s] = merge(ex[1-s], wd[s], b);
        check("write_end", r, 3'h4);
        check("tgt_word", tw[1-s], ex[1-s]);
      end
      xfer(s, `CBS_CMD_MEM_RD, 32'h2000 >> s, 4'hf, r);
      check("rdata", rd[s], ex[1-s]);
      xfer(s, `CBS_CMD_MEM_WR, (32'h2000 >> s) ^ 32'h4000, 4'hf, r);
      check("abort", r, 3'h1);
      xfer(s, `CBS_CMD_SPECIAL, 32'h2000 >> s, 4'hf, r);
      check("special", r, 3'h1);
    end
    check("lock_hold", rdy[0], 1'b0);
    lk = 1'b0;
    repeat (2) @(negedge clk);
    check("lock_free", rdy[0], 1'b1);
    for (int k = 0; k < 8; k++) begin
      {aud, irq, serr, fen, vs, det} = 8'($random(seed)) & (k < 2 ? 8'hfc : 8'hff);
      repeat (4) @(negedge clk);
      check("speaker", spk, aud);
      check("present", pres, det == 2'h0);
      check("volt", volt, vexp(vs, det));
      check("irq", cirq, irq);
      check("serr", hserr, !(fen && serr));
    end
    sts = 1'b1;
    repeat (2) @(negedge clk);
    check("alert", alert, 1'b1);
    repeat (2) @(negedge clk);
    check("alert_end", alert, 1'b0);
    check("wake", wake, 1'b1);
    wclr = 1'b1;
    repeat (2) @(negedge clk);
    check("wake_clr", wake, 1'b0);
    check("perr", n_perr, 0);
    final_report();
  end
endmodule : testbench
